// >>> logic/ucc_pkg.sv
// package of register map, field layout, reset values and types for the serial control slice
//
// What this block does
// - control_b bit 7 switches receiver on
// - control_b bit 6 switches transmitter on
// - control_b bit 4 arms start-of-frame detection
// - control_b bit 3 selects open-drain line drive
// - control_b bits 2:1 pick receive speed mode
// - control_b bit 0 selects multiprocessor mode
// - control_c bits 7:6 pick communication mode
// - mode three shows host SPI layout
// - control_c bits 5:4 select parity kind
// - control_c bit 3 sets transmit stop bits
// - control_c bits 2:0 set character width
// - SPI layout bit 2 selects bit order
// - SPI layout bit 1 selects clock phase
// - baud divisor is 16 bits, two bytes
// - any baud write reloads prescaler at once
// - nine-bit low-first launches on high byte write
package ucc_pkg;

    // apb geometry
    localparam int          APB_ADDR_W       = 12;
    localparam int          APB_DATA_W       = 32;
    localparam int          REG_IDX_W        = 10;

    // register indices, byte address is four times the index
    localparam logic [9:0]  IDX_TXDATA_LOW   = 10'h002;
    localparam logic [9:0]  IDX_TXDATA_HIGH  = 10'h003;
    localparam logic [9:0]  IDX_CONTROL_B    = 10'h006;
    localparam logic [9:0]  IDX_CONTROL_C    = 10'h007;
    localparam logic [9:0]  IDX_BAUD_LOW     = 10'h008;
    localparam logic [9:0]  IDX_BAUD_HIGH    = 10'h009;

    // control_b field positions
    localparam int          CB_RECEIVER_EN   = 7;
    localparam int          CB_TRANSMIT_EN   = 6;
    localparam int          CB_FRAME_START   = 4;
    localparam int          CB_OPEN_DRAIN    = 3;
    localparam int          CB_SPEED_HI      = 2;
    localparam int          CB_SPEED_LO      = 1;
    localparam int          CB_MULTIPROC     = 0;
    localparam logic [7:0]  CB_WRITE_MASK    = 8'hdf;

    // control_c field positions, frame and SPI layouts
    localparam int          CC_MODE_HI       = 7;
    localparam int          CC_MODE_LO       = 6;
    localparam int          CC_PARITY_HI     = 5;
    localparam int          CC_PARITY_LO     = 4;
    localparam int          CC_STOP          = 3;
    localparam int          CC_CHAR_HI       = 2;
    localparam int          CC_CHAR_LO       = 0;
    localparam int          CC_BIT_ORDER     = 2;
    localparam int          CC_CLOCK_PHASE   = 1;
    localparam logic [7:0]  CC_SPI_MASK      = 8'hc6;

    // reset values
    localparam logic [7:0]  CONTROL_B_RESET  = 8'h00;
    localparam logic [7:0]  CONTROL_C_RESET  = 8'h03;
    localparam logic [15:0] BAUD_RESET       = 16'h0000;
    localparam logic [7:0]  TXDATA_RESET     = 8'h00;

    // frame counts
    localparam logic [3:0]  CHAR_BASE_BITS   = 4'h5;
    localparam logic [3:0]  NINE_BITS        = 4'h9;
    localparam logic [3:0]  SPI_DATA_BITS    = 4'h8;
    localparam logic [1:0]  STOP_ONE         = 2'h1;
    localparam logic [1:0]  STOP_TWO         = 2'h2;

    typedef enum logic [1:0] {
        RXM_NORMAL           = 2'h0,
        RXM_DOUBLE_SPEED     = 2'h1,
        RXM_GENERIC_AUTOBAUD = 2'h2,
        RXM_LIN_AUTOBAUD     = 2'h3
    } ucc_rx_mode_t;

    typedef enum logic [1:0] {
        CM_ASYNC         = 2'h0,
        CM_SYNC          = 2'h1,
        CM_INFRARED_MODE = 2'h2,
        CM_HOST_SPI_MODE = 2'h3
    } ucc_comm_mode_t;

    typedef enum logic [1:0] {
        PAR_NONE     = 2'h0,
        PAR_RESERVED = 2'h1,
        PAR_EVEN     = 2'h2,
        PAR_ODD      = 2'h3
    } ucc_parity_t;

    typedef enum logic [2:0] {
        CH_5_BITS              = 3'h0,
        CH_6_BITS              = 3'h1,
        CH_7_BITS              = 3'h2,
        CH_8_BITS              = 3'h3,
        CH_RESERVED_4          = 3'h4,
        CH_RESERVED_5          = 3'h5,
        CH_NINE_BIT_LOW_FIRST  = 3'h6,
        CH_NINE_BIT_HIGH_FIRST = 3'h7
    } ucc_char_t;

    // decoded configuration handed to the serial engines
    typedef struct packed {
        logic           receiverEnable;
        logic           transmitterEnable;
        logic           frameStartDetectEnable;
        logic           openDrainEnable;
        ucc_rx_mode_t   receiveSpeedMode;
        logic           multiprocessorMode;
        ucc_comm_mode_t commModeSelect;
        logic           hostSpiMode;
        logic           parityEnable;
        logic           parityOdd;
        logic [1:0]     stopBitCount;
        logic [3:0]     dataBits;
        logic           charReserved;
        logic           nineBitLowFirst;
        logic           nineBitHighFirst;
        logic           bitOrderLsbFirst;
        logic           clockPhaseTrailing;
        logic [15:0]    baudDivisor;
    } ucc_cfg_t;

    // character launched toward the transmitter
    typedef struct packed {
        logic       launch;
        logic [8:0] data;
    } ucc_tx_word_t;

endpackage : ucc_pkg

// >>> logic/ucc_baud_prescaler.sv
// baud prescaler: down counter reloaded from the divisor, one tick per wrap
`timescale 1ns/1ps
`default_nettype none
module ucc_baud_prescaler
    import ucc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        reload,
    input  wire logic [15:0] divisor,
    input  wire logic        run,
    output logic             tick
);

    logic [15:0] countReg;

    // count down, wrap to the divisor; a reload wins over counting
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            countReg <= BAUD_RESET;
            tick     <= 1'b0;
        end else if (reload) begin
            countReg <= divisor;
            tick     <= 1'b0;
        end else if (run) begin
            if (countReg == 16'h0000) begin
                countReg <= divisor;
                tick     <= 1'b1;
            end else begin
                countReg <= countReg - 16'h0001;
                tick     <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule : ucc_baud_prescaler
`default_nettype wire

// >>> logic/ucc_control_config.sv
// serial transceiver control slice: apb registers, decoded configuration, line drive
`timescale 1ns/1ps
`default_nettype none
module ucc_control_config
    import ucc_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [APB_DATA_W-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [APB_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  txLineLevel,
    input  wire logic                  rxLineIn,
    output logic                       txPinOut,
    output logic                       txPinOe,
    output logic                       rxLineToCore,
    output ucc_cfg_t                   cfgOut,
    output ucc_tx_word_t               txWordOut,
    output logic                       baudTick
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // word index of a byte address
    function automatic logic [REG_IDX_W-1:0] regIndex(input logic [APB_ADDR_W-1:0] addr);
        regIndex = addr[APB_ADDR_W-1:2];
    endfunction : regIndex

    // true for an aligned address that hits one of our registers
    function automatic logic isMapped(input logic [APB_ADDR_W-1:0] addr);
        logic [REG_IDX_W-1:0] idx;
        idx = regIndex(addr);
        isMapped = (addr[1:0] == 2'h0) &&
                   ((idx == IDX_TXDATA_LOW)  || (idx == IDX_TXDATA_HIGH) ||
                    (idx == IDX_CONTROL_B)   || (idx == IDX_CONTROL_C)   ||
                    (idx == IDX_BAUD_LOW)    || (idx == IDX_BAUD_HIGH));
    endfunction : isMapped

    // value stored into control_c, shaped by the layout the write selects
    function automatic logic [7:0] shapeControlC(input logic [7:0] wr);
        if (wr[CC_MODE_HI:CC_MODE_LO] == CM_HOST_SPI_MODE) begin
            shapeControlC = wr & CC_SPI_MASK;
        end else begin
            shapeControlC = wr;
        end
    endfunction : shapeControlC

    // turn the raw registers into the decoded configuration
    function automatic ucc_cfg_t decodeConfig(input logic [7:0]  cb,
                                              input logic [7:0]  cc,
                                              input logic [15:0] baud);
        ucc_cfg_t  c;
        ucc_char_t ch;
        c  = '0;
        ch = ucc_char_t'(cc[CC_CHAR_HI:CC_CHAR_LO]);
        c.receiverEnable         = cb[CB_RECEIVER_EN];
        c.transmitterEnable      = cb[CB_TRANSMIT_EN];
        c.frameStartDetectEnable = cb[CB_FRAME_START];
        c.openDrainEnable        = cb[CB_OPEN_DRAIN];
        c.receiveSpeedMode       = ucc_rx_mode_t'(cb[CB_SPEED_HI:CB_SPEED_LO]);
        c.multiprocessorMode     = cb[CB_MULTIPROC];
        c.commModeSelect         = ucc_comm_mode_t'(cc[CC_MODE_HI:CC_MODE_LO]);
        c.hostSpiMode            = (c.commModeSelect == CM_HOST_SPI_MODE);
        c.baudDivisor            = baud;
        if (c.hostSpiMode) begin
            // SPI layout: frame fields replaced by order and phase
            c.parityEnable       = 1'b0;
            c.parityOdd          = 1'b0;
            c.stopBitCount       = STOP_ONE;
            c.dataBits           = SPI_DATA_BITS;
            c.charReserved       = 1'b0;
            c.nineBitLowFirst    = 1'b0;
            c.nineBitHighFirst   = 1'b0;
            c.bitOrderLsbFirst   = cc[CC_BIT_ORDER];
            c.clockPhaseTrailing = cc[CC_CLOCK_PHASE];
        end else begin
            // frame layout: parity, stop bits and width
            case (ucc_parity_t'(cc[CC_PARITY_HI:CC_PARITY_LO]))
                PAR_EVEN: begin
                    c.parityEnable = 1'b1;
                    c.parityOdd    = 1'b0;
                end
                PAR_ODD: begin
                    c.parityEnable = 1'b1;
                    c.parityOdd    = 1'b1;
                end
                default: begin
                    c.parityEnable = 1'b0; // none and the reserved code send no parity
                    c.parityOdd    = 1'b0;
                end
            endcase
            c.stopBitCount = cc[CC_STOP] ? STOP_TWO : STOP_ONE;
            case (ch)
                CH_5_BITS, CH_6_BITS, CH_7_BITS, CH_8_BITS: begin
                    c.dataBits = CHAR_BASE_BITS + {2'h0, cc[1:0]};
                end
                CH_NINE_BIT_LOW_FIRST: begin
                    c.dataBits        = NINE_BITS;
                    c.nineBitLowFirst = 1'b1;
                end
                CH_NINE_BIT_HIGH_FIRST: begin
                    c.dataBits         = NINE_BITS;
                    c.nineBitHighFirst = 1'b1;
                end
                default: begin
                    c.dataBits     = SPI_DATA_BITS; // reserved codes flagged, run as 8
                    c.charReserved = 1'b1;
                end
            endcase
            c.bitOrderLsbFirst   = 1'b0;
            c.clockPhaseTrailing = 1'b0;
        end
        decodeConfig = c;
    endfunction : decodeConfig

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------

    logic [7:0]            controlBReg;
    logic [7:0]            controlCReg;
    logic [15:0]           baudReg;
    logic [7:0]            txLowReg;
    logic                  txHighReg;
    logic                  slvErrReg;
    logic [APB_DATA_W-1:0] readDataReg;

    // bus phase decode
    logic                  setupPhase;
    logic                  accessPhase;
    logic                  writeTaken;
    logic [REG_IDX_W-1:0]  accIdx;
    logic                  wrControlB;
    logic                  wrControlC;
    logic                  wrBaudLow;
    logic                  wrBaudHigh;
    logic                  wrTxLow;
    logic                  wrTxHigh;
    logic                  baudReload;
    logic                  nineLowFirstNow;

    assign setupPhase  = psel & ~penable;
    assign accessPhase = psel & penable;
    assign accIdx      = regIndex(paddr);

    // writes land at the access edge, lane 0 carries every register
    assign writeTaken  = accessPhase & pwrite & pstrb[0] & ~slvErrReg;
    assign wrControlB  = writeTaken & (accIdx == IDX_CONTROL_B);
    assign wrControlC  = writeTaken & (accIdx == IDX_CONTROL_C);
    assign wrBaudLow   = writeTaken & (accIdx == IDX_BAUD_LOW);
    assign wrBaudHigh  = writeTaken & (accIdx == IDX_BAUD_HIGH);
    assign wrTxLow     = writeTaken & (accIdx == IDX_TXDATA_LOW);
    assign wrTxHigh    = writeTaken & (accIdx == IDX_TXDATA_HIGH);
    assign baudReload  = wrBaudLow | wrBaudHigh;

    // zero wait state slave; error only for unmapped addresses
    assign pready  = 1'b1;
    assign pslverr = accessPhase & slvErrReg;
    assign prdata  = readDataReg;

    // control_b, unused bit 5 never stored
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            controlBReg <= CONTROL_B_RESET;
        end else if (wrControlB) begin
            controlBReg <= pwdata[7:0] & CB_WRITE_MASK;
        end
    end

    // control_c, layout chosen by the mode being written
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            controlCReg <= CONTROL_C_RESET;
        end else if (wrControlC) begin
            controlCReg <= shapeControlC(pwdata[7:0]);
        end
    end

    // baud divisor bytes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            baudReg <= BAUD_RESET;
        end else if (wrBaudLow) begin
            baudReg[7:0] <= pwdata[7:0];
        end else if (wrBaudHigh) begin
            baudReg[15:8] <= pwdata[7:0];
        end
    end

    // transmit holding bytes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txLowReg  <= TXDATA_RESET;
            txHighReg <= 1'b0;
        end else begin
            if (wrTxLow) begin
                txLowReg <= pwdata[7:0];
            end
            if (wrTxHigh) begin
                txHighReg <= pwdata[0];
            end
        end
    end

    // the byte that completes a character launches it
    assign nineLowFirstNow =
        (ucc_char_t'(controlCReg[CC_CHAR_HI:CC_CHAR_LO]) == CH_NINE_BIT_LOW_FIRST) &&
        (controlCReg[CC_MODE_HI:CC_MODE_LO] != CM_HOST_SPI_MODE);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txWordOut <= '0;
        end else if (nineLowFirstNow && wrTxHigh) begin
            txWordOut.launch <= 1'b1;
            txWordOut.data   <= {pwdata[0], txLowReg};
        end else if (!nineLowFirstNow && wrTxLow) begin
            txWordOut.launch <= 1'b1;
            txWordOut.data   <= {txHighReg, pwdata[7:0]};
        end else begin
            txWordOut.launch <= 1'b0;
        end
    end

    // unmapped check and read data captured in the setup cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slvErrReg   <= 1'b0;
            readDataReg <= '0;
        end else if (setupPhase) begin
            slvErrReg   <= ~isMapped(paddr);
            readDataReg <= '0;
            if (!pwrite && isMapped(paddr)) begin
                case (regIndex(paddr))
                    IDX_TXDATA_LOW:  readDataReg[7:0] <= txLowReg;
                    IDX_TXDATA_HIGH: readDataReg[0]   <= txHighReg;
                    IDX_CONTROL_B:   readDataReg[7:0] <= controlBReg;
                    IDX_CONTROL_C:   readDataReg[7:0] <= controlCReg;
                    IDX_BAUD_LOW:    readDataReg[7:0] <= baudReg[7:0];
                    IDX_BAUD_HIGH:   readDataReg[7:0] <= baudReg[15:8];
                    default:         readDataReg      <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // decoded configuration and line handling
    // ------------------------------------------------------------

    ucc_cfg_t cfgNext;

    assign cfgNext = decodeConfig(controlBReg, controlCReg, baudReg);

    // registered copy, one cycle behind the register file
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgOut <= decodeConfig(CONTROL_B_RESET, CONTROL_C_RESET, BAUD_RESET);
        end else begin
            cfgOut <= cfgNext;
        end
    end

    // transmit pin: push-pull or open-drain, released while transmitter off
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txPinOut <= 1'b0;
            txPinOe  <= 1'b0;
        end else if (!controlBReg[CB_TRANSMIT_EN]) begin
            txPinOut <= 1'b0;
            txPinOe  <= 1'b0;
        end else if (controlBReg[CB_OPEN_DRAIN]) begin
            txPinOut <= 1'b0;
            txPinOe  <= ~txLineLevel;
        end else begin
            txPinOut <= txLineLevel;
            txPinOe  <= 1'b1;
        end
    end

    // receive path held at idle level while receiver off
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxLineToCore <= 1'b1;
        end else begin
            rxLineToCore <= controlBReg[CB_RECEIVER_EN] ? rxLineIn : 1'b1;
        end
    end

    // bit-rate prescaler, runs while either direction is on
    ucc_baud_prescaler u_prescaler (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .reload  (baudReload),
        .divisor (wrBaudLow  ? {baudReg[15:8], pwdata[7:0]} :
                  wrBaudHigh ? {pwdata[7:0], baudReg[7:0]}  : baudReg),
        .run     (controlBReg[CB_RECEIVER_EN] | controlBReg[CB_TRANSMIT_EN]),
        .tick    (baudTick)
    );

endmodule : ucc_control_config
`default_nettype wire

// >>> verif/ucc_remote_peer.sv
// remote serial transmitter model that feeds the receive pin
`timescale 1ns/1ps
`default_nettype none
module ucc_remote_peer #(parameter int BIT_CYC = 4) (
    input  wire logic       ref_clk,
    input  wire logic       send,
    input  wire logic [7:0] sendByte,
    output logic            rxLine
);
    logic [9:0] frame = 10'h3ff;
    int         cnt   = 0;
    // idle line rests high; frame is start, eight bits lsb first, stop
    always @(posedge ref_clk) begin
        if (send) begin
            frame <= {1'b1, sendByte, 1'b0};
            cnt   <= 0;
        end else if (cnt == BIT_CYC - 1) begin
            frame <= {1'b1, frame[9:1]};
            cnt   <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    assign rxLine = frame[0];
endmodule : ucc_remote_peer
`default_nettype wire

// >>> verif/ucc_control_config_sva.sv
// port checker for the serial control slice
`timescale 1ns/1ps
`default_nettype none
module ucc_control_config_sva
    import ucc_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         sys_rst,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [3:0]   pstrb,
    input wire logic         txLineLevel,
    input wire logic         txPinOut,
    input wire logic         txPinOe,
    input wire logic         rxLineToCore,
    input wire ucc_cfg_t     cfgOut,
    input wire ucc_tx_word_t txWordOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // accepted write strobe and register index
    wire [9:0] ix = paddr[11:2];
    wire wr = psel && penable && pwrite && pstrb[0] && paddr[1:0] == 2'h0;
    a_cb_decode: assert property (wr && ix == IDX_CONTROL_B |=> ##1
        {cfgOut.receiverEnable, cfgOut.transmitterEnable, cfgOut.frameStartDetectEnable,
         cfgOut.openDrainEnable, cfgOut.receiveSpeedMode, cfgOut.multiprocessorMode}
        == {$past(pwdata[7:6], 2), $past(pwdata[4:0], 2)}) else $error("control_b decode");
    a_frame_decode: assert property (wr && ix == IDX_CONTROL_C && pwdata[7:6] != 2'h3
        && !pwdata[2] |=> ##1 cfgOut.commModeSelect == $past(pwdata[7:6], 2)
        && cfgOut.parityEnable == $past(pwdata[5], 2)
        && cfgOut.parityOdd == ($past(pwdata[5:4], 2) == 2'h3)
        && cfgOut.stopBitCount == ($past(pwdata[3], 2) ? STOP_TWO : STOP_ONE)
        && cfgOut.dataBits == CHAR_BASE_BITS + $past(pwdata[1:0], 2))
        else $error("frame layout decode");
    a_spi_layout: assert property (cfgOut.commModeSelect == CM_HOST_SPI_MODE |->
        cfgOut.hostSpiMode && !cfgOut.parityEnable && cfgOut.dataBits == SPI_DATA_BITS)
        else $error("spi layout fields");
    a_spi_bits: assert property (wr && ix == IDX_CONTROL_C && pwdata[7:6] == 2'h3
        |=> ##1 cfgOut.bitOrderLsbFirst == $past(pwdata[2], 2)
        && cfgOut.clockPhaseTrailing == $past(pwdata[1], 2)) else $error("spi order or phase");
    a_baud_high: assert property (wr && ix == IDX_BAUD_HIGH |=> ##1
        cfgOut.baudDivisor[15:8] == $past(pwdata[7:0], 2)) else $error("baud high byte");
    a_launch_byte: assert property (wr && ix == (cfgOut.nineBitLowFirst ?
        IDX_TXDATA_HIGH : IDX_TXDATA_LOW) |=> txWordOut.launch) else $error("no launch");
    a_tx_off: assert property (!cfgOut.transmitterEnable |-> !txPinOe)
        else $error("pin driven while transmitter off");
    a_drain_drive: assert property (cfgOut.transmitterEnable && cfgOut.openDrainEnable
        |-> !txPinOut && txPinOe == !$past(txLineLevel)) else $error("open drain drive");
    a_push_drive: assert property (cfgOut.transmitterEnable && !cfgOut.openDrainEnable
        |-> txPinOe && txPinOut == $past(txLineLevel)) else $error("normal drive");
    a_rx_idle: assert property (!cfgOut.receiverEnable |-> rxLineToCore)
        else $error("receive path not idle");
endmodule : ucc_control_config_sva
bind ucc_control_config ucc_control_config_sva chk (.ref_clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .txLineLevel, .txPinOut, .txPinOe, .rxLineToCore,
    .cfgOut, .txWordOut);
`default_nettype wire

// >>> verif/tb_ucc_control_config.sv
// self-checking bench for the serial control slice
`timescale 1ns/1ps
`default_nettype none
module tb_ucc_control_config
    import ucc_pkg::*;
;
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, txLineLevel = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, v, rng = 32'hf35504a4;
    logic [3:0] pstrb = 4'h1;
    logic pready, pslverr, rxLineIn, txPinOut, txPinOe, rxLineToCore, baudTick, prev;
    logic sendNow = 0;
    ucc_cfg_t cfgOut;
    ucc_tx_word_t txWordOut;
    logic [31:0] readQ[$];
    logic [8:0] launchQ[$];
    int fail_count = 0, tests_run = 0, ticks = 0;
    ucc_control_config uut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .txLineLevel, .rxLineIn, .txPinOut, .txPinOe,
        .rxLineToCore, .cfgOut, .txWordOut, .baudTick);
    ucc_remote_peer peer (.ref_clk, .send(sendNow), .sendByte(8'h96), .rxLine(rxLineIn));
    initial forever #10 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs();
        rng ^= rng << 13; rng ^= rng >> 17; rng ^= rng << 5;
        return rng;
    endfunction : xs
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk); penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
        @(posedge ref_clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        readQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // compare read data and launched words against the queued notes
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite) check(prdata, readQ.pop_front());
        if (psel && penable && pready) check(pslverr, !(paddr inside {12'h008, 12'h00c,
            12'h018, 12'h01c, 12'h020, 12'h024}));
        if (txWordOut.launch === 1'b1) begin
            if (launchQ.size() == 0) check(32'h0, 32'h1);
            else check({23'h0, txWordOut.data}, {23'h0, launchQ.pop_front()});
        end
    end
    // engine line level wanders at random
    always @(posedge ref_clk) txLineLevel <= ^xs();
    initial begin #200us; fail_count++; report_and_stop(); end
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 0;
        @(posedge ref_clk);
        rd(12'h018, 32'h0); rd(12'h01c, 32'h3); rd(12'h020, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 256; i++) begin // no transfer runs, order bit free
            wr(12'h01c, i);
            rd(12'h01c, i[7:6] == 2'h3 ? i & 32'hc6 : i);
        end
        wr(12'h01c, 32'h43); // synchronous mode so every speed mode is legal
        repeat (40) begin
            v = xs() & 32'hff;
            wr(12'h018, v);
            rd(12'h018, v & 32'hdf);
        end
        pstrb <= 4'h0;
        wr(12'h018, 32'hff);
        pstrb <= 4'h1;
        rd(12'h018, v & 32'hdf);
        rd(12'h028, 32'h0); rd(12'h019, 32'h0);
        $display("control registers done");
        v = xs() & 32'hffff;
        wr(12'h020, v & 32'hff); wr(12'h024, v >> 8); // line idle
        rd(12'h020, v & 32'hff); rd(12'h024, v >> 8);
        wr(12'h018, 32'h40); wr(12'h020, 32'h3); wr(12'h024, 32'h0);
        @(posedge ref_clk iff baudTick === 1'b1);
        repeat (16) begin @(posedge ref_clk); ticks += baudTick; end
        check(ticks, 4);
        $display("baud done");
        wr(12'h01c, 32'h06); wr(12'h008, 32'h5a);
        launchQ.push_back(9'h15a); wr(12'h00c, 32'h1);
        wr(12'h01c, 32'h03); wr(12'h00c, 32'h1);
        launchQ.push_back(9'h1a5); wr(12'h008, 32'ha5);
        @(posedge ref_clk);
        check(launchQ.size(), 0);
        $display("launch done");
        wr(12'h018, 32'h80);
        sendNow <= 1; @(posedge ref_clk); sendNow <= 0;
        repeat (50) begin
            #1 prev = rxLineIn;
            @(posedge ref_clk);
            #1 check(rxLineToCore, prev);
        end
        $display("receive path done");
        report_and_stop();
    end
endmodule : tb_ucc_control_config
`default_nettype wire
